// ===== src/crcu_pkg.sv
// crcu_pkg: register map, reset values, field layout and encodings of the CRC unit.
// assumes a single AHB-Lite master, word-aligned accesses, one clock core_clk.

package crcu_pkg;

   localparam int ADDR_W   = 5;
   localparam int DATA_W   = 32;
   localparam int FIFO_DEP = 8;

   localparam logic [ADDR_W-1:0] OFF_RESULT  = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_SCRATCH = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_CONTROL = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_INITVAL = 5'h10;
   localparam logic [ADDR_W-1:0] OFF_GENVAL  = 5'h14;

   localparam logic [31:0] RESULT_RST  = 32'hFFFFFFFF;
   localparam logic [31:0] INITVAL_RST = 32'hFFFFFFFF;
   localparam logic [31:0] GENVAL_RST  = 32'h04C11DB7;
   localparam logic [7:0]  SCRATCH_RST = 8'h00;

   localparam int CTL_RESTART_BIT = 0;
   localparam int CTL_SIZE_LSB    = 3;
   localparam int CTL_REVIN_LSB   = 5;
   localparam int CTL_REVOUT_BIT  = 7;

   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef enum logic [1:0] {
      SZ32 = 2'b00,
      SZ16 = 2'b01,
      SZ8  = 2'b10,
      SZ7  = 2'b11
   } crcu_size_e;

   typedef enum logic [1:0] {
      REV_NONE = 2'b00,
      REV_BYTE = 2'b01,
      REV_HALF = 2'b10,
      REV_WORD = 2'b11
   } crcu_rev_e;

   typedef enum logic {
      ENG_IDLE = 1'b0,
      ENG_RUN  = 1'b1
   } crcu_eng_e;

   localparam crcu_size_e SIZE_RST  = SZ32;
   localparam crcu_rev_e  REVIN_RST = REV_NONE;
   localparam logic       REVOUT_RST = 1'b0;

endpackage

// ===== src/crcu_stream_if.sv
// crcu_stream_if: valid/ready word stream between the bus side and the CRC engine.
// assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface crcu_stream_if #(parameter int W = 32);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;

   modport mst (output valid, output data, input ready);
   modport slv (input valid, input data, output ready);
endinterface

`default_nettype wire

// ===== src/crcu_fifo.sv
// crcu_fifo: synchronous FIFO with valid/ready on both sides.
// assumes one clock; full shows as inPort.ready low, empty as outPort.valid low.
`timescale 1ns/1ps
`default_nettype none

module crcu_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 8
) (
   input wire logic    clk,      // core clock
   input wire logic    nrst,     // async reset, active low
   crcu_stream_if.slv  inPort,   // filling side
   crcu_stream_if.mst  outPort   // draining side
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0]  mem [DEPTH];
   logic [PW-1:0] wrPtr_ff;
   logic [PW-1:0] rdPtr_ff;
   logic [CW-1:0] count_ff;
   logic          push;
   logic          pop;

   assign inPort.ready  = (count_ff != CW'(DEPTH));
   assign outPort.valid = (count_ff != '0);
   assign outPort.data  = mem[rdPtr_ff];
   assign push = inPort.valid & inPort.ready;
   assign pop  = outPort.valid & outPort.ready;

   // storage has no reset; only the pointers and count_ff define what is valid
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_ff] <= inPort.data;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
      end else begin
         if (push) begin
            wrPtr_ff <= (wrPtr_ff == PW'(DEPTH - 1)) ? '0 : wrPtr_ff + PW'(1);
         end
         if (pop) begin
            rdPtr_ff <= (rdPtr_ff == PW'(DEPTH - 1)) ? '0 : rdPtr_ff + PW'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count_ff <= '0;
      end else begin
         case ({push, pop})
            2'b10:   count_ff <= count_ff + CW'(1);
            2'b01:   count_ff <= count_ff - CW'(1);
            default: count_ff <= count_ff;
         endcase
      end
   end

endmodule

`default_nettype wire

// ===== src/crcu_top.sv
// crcu_top: CRC calculation unit with AHB-Lite register slave.
// assumes an AHB-Lite master on core_clk; HREADY is the bus-wide ready.
`timescale 1ns/1ps
`default_nettype none

module crcu_top
   import crcu_pkg::*;
(
   input  wire logic              core_clk,   // 20 MHz bus clock
   input  wire logic              nrst,       // async reset, active low
   input  wire logic              HSEL,       // slave select
   input  wire logic [ADDR_W-1:0] HADDR,      // byte address, low bits
   input  wire logic [1:0]        HTRANS,     // transfer type
   input  wire logic              HWRITE,     // write when high
   input  wire logic [2:0]        HSIZE,      // transfer size
   input  wire logic [31:0]       HWDATA,     // write data
   input  wire logic              HREADY,     // bus ready in
   output logic [31:0]            HRDATA,     // read data
   output logic                   HREADYOUT,  // slave ready out
   output logic                   HRESP       // error response
);

   // ---- bus address/data phase ----
   logic              dpValid_ff;
   logic              dpWrite_ff;
   logic              dpWord_ff;
   logic [ADDR_W-1:0] dpAddr_ff;
   logic              errCyc_ff;
   logic              addrTake;
   logic              dpMapped;
   logic              dpDone;
   logic              stall;

   // ---- registers ----
   logic [31:0] result_ff;
   logic [31:0] initVal_ff;
   logic [31:0] genVal_ff;
   logic [7:0]  scratch_ff;
   crcu_size_e  size_ff;
   crcu_rev_e   revIn_ff;
   logic        revOut_ff;

   // ---- engine ----
   crcu_eng_e   engState_ff;
   logic [1:0]  byteIdx_ff;
   logic [31:0] curWord_ff;
   logic [1:0]  lastIdx;
   logic [5:0]  crcWidth;
   logic        popFire;
   logic        busyAny;

   // ---- write strobes ----
   logic resultWr;
   logic scratchWr;
   logic ctrlWr;
   logic initWr;
   logic genWr;
   logic restart;

   // ---- datapath ----
   logic [31:0] revByte;
   logic [31:0] revHalf;
   logic [31:0] revWord;
   logic [31:0] inWord;
   logic [31:0] widthMask;
   logic [31:0] resMasked;
   logic [31:0] resRev;
   logic [31:0] resView;
   logic [31:0] ctrlView;

   crcu_stream_if #(.W(DATA_W)) pushIf ();
   crcu_stream_if #(.W(DATA_W)) popIf ();

   crcu_fifo #(
      .W     (DATA_W),
      .DEPTH (FIFO_DEP)
   ) u_fifo (
      .clk     (core_clk),
      .nrst    (nrst),
      .inPort  (pushIf),
      .outPort (popIf)
   );

   assign addrTake = HSEL & HREADY & HTRANS[1];

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         dpValid_ff <= 1'b0;
         dpWrite_ff <= 1'b0;
         dpWord_ff  <= 1'b0;
         dpAddr_ff  <= '0;
      end else if (HREADY) begin
         dpValid_ff <= addrTake;
         dpWrite_ff <= HWRITE;
         dpWord_ff  <= (HSIZE == HSIZE_WORD);
         dpAddr_ff  <= HADDR;
      end
   end

   always_comb begin
      case (dpAddr_ff)
         OFF_RESULT, OFF_SCRATCH, OFF_CONTROL, OFF_INITVAL, OFF_GENVAL: dpMapped = 1'b1;
         default: dpMapped = 1'b0;
      endcase
   end

   // data writes stall only when all 8 slots are taken; reads of the
   // result wait until every queued word is folded in
   assign busyAny = popIf.valid | (engState_ff == ENG_RUN);
   assign stall = dpWrite_ff ? (dpAddr_ff == OFF_RESULT && !pushIf.ready)
                             : (dpAddr_ff == OFF_RESULT && busyAny);
   assign HREADYOUT = !(dpValid_ff && (dpMapped ? stall : !errCyc_ff));
   assign HRESP     = dpValid_ff & !dpMapped;
   // sub-word writes are completed but ignored; sub-word reads still return register data
   assign dpDone    = dpValid_ff & dpMapped & HREADYOUT & dpWord_ff;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         errCyc_ff <= 1'b0;
      end else begin
         errCyc_ff <= dpValid_ff & !dpMapped & !errCyc_ff;
      end
   end

   assign resultWr  = dpDone & dpWrite_ff & (dpAddr_ff == OFF_RESULT);
   assign scratchWr = dpDone & dpWrite_ff & (dpAddr_ff == OFF_SCRATCH);
   assign ctrlWr    = dpDone & dpWrite_ff & (dpAddr_ff == OFF_CONTROL);
   assign initWr    = dpDone & dpWrite_ff & (dpAddr_ff == OFF_INITVAL);
   assign genWr     = dpDone & dpWrite_ff & (dpAddr_ff == OFF_GENVAL);
   assign restart   = ctrlWr & HWDATA[CTL_RESTART_BIT];

   // written word goes to the queue, never into the result
   assign pushIf.valid = dpValid_ff & dpWrite_ff & dpWord_ff & (dpAddr_ff == OFF_RESULT);
   assign pushIf.data  = HWDATA;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         scratch_ff <= SCRATCH_RST;
      end else if (scratchWr) begin
         scratch_ff <= HWDATA[7:0];
      end
   end

   // restart flag is never stored, so it reads back as zero
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         size_ff   <= SIZE_RST;
         revIn_ff  <= REVIN_RST;
         revOut_ff <= REVOUT_RST;
      end else if (ctrlWr) begin
         size_ff   <= crcu_size_e'(HWDATA[CTL_SIZE_LSB +: 2]);
         revIn_ff  <= crcu_rev_e'(HWDATA[CTL_REVIN_LSB +: 2]);
         revOut_ff <= HWDATA[CTL_REVOUT_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         initVal_ff <= INITVAL_RST;
         genVal_ff  <= GENVAL_RST;
      end else begin
         if (initWr) begin
            initVal_ff <= HWDATA;
         end
         if (genWr) begin
            genVal_ff <= HWDATA;
         end
      end
   end

   // ---- input and output reversal ----
   genvar i;
   generate
      for (i = 0; i < 32; i++) begin : g_rev
         assign revByte[i] = popIf.data[(i / 8) * 8 + 7 - (i % 8)];
         assign revHalf[i] = popIf.data[(i / 16) * 16 + 15 - (i % 16)];
         assign revWord[i] = popIf.data[31 - i];
         assign resRev[i]  = resMasked[31 - i];
      end
   endgenerate

   always_comb begin
      case (revIn_ff)
         REV_BYTE: inWord = revByte;
         REV_HALF: inWord = revHalf;
         REV_WORD: inWord = revWord;
         default:  inWord = popIf.data;
      endcase
   end

   // width and byte count per size; 7-bit still folds a whole byte
   always_comb begin
      case (size_ff)
         SZ16: begin
            crcWidth = 6'd16;
            lastIdx  = 2'd1;
         end
         SZ8: begin
            crcWidth = 6'd8;
            lastIdx  = 2'd0;
         end
         SZ7: begin
            crcWidth = 6'd7;
            lastIdx  = 2'd0;
         end
         default: begin
            crcWidth = 6'd32;
            lastIdx  = 2'd3;
         end
      endcase
   end

   assign widthMask = (crcWidth == 6'd32) ? 32'hFFFFFFFF
                                          : ((32'h00000001 << crcWidth) - 32'h00000001);
   assign resMasked = result_ff & widthMask;
   assign resView   = revOut_ff ? resRev : resMasked;
   assign ctrlView  = {24'h000000, revOut_ff, revIn_ff, size_ff, 3'h0};

   always_comb begin
      HRDATA = 32'h00000000;
      if (dpValid_ff && !dpWrite_ff) begin
         case (dpAddr_ff)
            OFF_RESULT:  HRDATA = resView;
            OFF_SCRATCH: HRDATA = {24'h000000, scratch_ff};
            OFF_CONTROL: HRDATA = ctrlView;
            OFF_INITVAL: HRDATA = initVal_ff;
            OFF_GENVAL:  HRDATA = genVal_ff;
            default:     HRDATA = 32'h00000000;
         endcase
      end
   end

   // one byte per clock, MSB first, shift-left form
   function automatic logic [31:0] crcu_step8(input logic [31:0] crc,
                                              input logic [7:0]  din,
                                              input logic [31:0] generator_value_reg,
                                              input logic [31:0] mask,
                                              input logic [5:0]  width);
      logic [31:0] c;
      logic        fb;
      c = crc & mask;
      for (int b = 7; b >= 0; b--) begin
         fb = c[5'(width - 6'd1)] ^ din[b];
         c  = (c << 1) & mask;
         if (fb) begin
            c = c ^ (generator_value_reg & mask);
         end
      end
      return c;
   endfunction

   // ---- engine ----
   assign popIf.ready = (engState_ff == ENG_IDLE);
   assign popFire     = popIf.valid & popIf.ready;

   // reversal and byte count are sampled when a word leaves the queue; the width follows size_ff live
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         engState_ff <= ENG_IDLE;
         byteIdx_ff  <= 2'd0;
         curWord_ff  <= 32'h00000000;
      end else begin
         case (engState_ff)
            ENG_IDLE: begin
               if (popFire) begin
                  engState_ff <= ENG_RUN;
                  byteIdx_ff  <= lastIdx;
                  curWord_ff  <= inWord;
               end
            end
            ENG_RUN: begin
               if (byteIdx_ff == 2'd0) begin
                  engState_ff <= ENG_IDLE;
               end else begin
                  byteIdx_ff <= byteIdx_ff - 2'd1;
               end
            end
            default: engState_ff <= ENG_IDLE;
         endcase
      end
   end

   // a restart wins over a byte in flight; queued words still follow it
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         result_ff <= RESULT_RST;
      end else if (restart) begin
         result_ff <= initVal_ff;
      end else if (initWr) begin
         result_ff <= HWDATA;
      end else if (engState_ff == ENG_RUN) begin
         result_ff <= crcu_step8(result_ff, curWord_ff[8 * byteIdx_ff +: 8],
                                 genVal_ff, widthMask, crcWidth);
      end
   end

   // ---- checks ----
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   chk_restart_load: assert property (
      restart |=> (result_ff == $past(initVal_ff)))
      else $error("restart did not load initial value");

   chk_init_load: assert property (
      (initWr && !restart) |=> (result_ff == $past(HWDATA)) && (initVal_ff == result_ff))
      else $error("initial-value write did not load result");

   chk_restart_clear: assert property (
      (dpDone && !dpWrite_ff && dpAddr_ff == OFF_CONTROL) |-> (HRDATA[CTL_RESTART_BIT] == 1'b0))
      else $error("restart bit reads back set");

   chk_scratch_keep: assert property (
      ctrlWr |=> $stable(scratch_ff))
      else $error("control write changed scratch byte");

   chk_cycles_word: assert property (
      (popFire && size_ff == SZ32) |=> (engState_ff == ENG_RUN) [*4] ##1 (engState_ff == ENG_IDLE))
      else $error("32-bit calculation not 4 cycles");

   chk_cycles_half: assert property (
      (popFire && size_ff == SZ16) |=> (engState_ff == ENG_RUN) [*2] ##1 (engState_ff == ENG_IDLE))
      else $error("16-bit calculation not 2 cycles");

   chk_write_nowait: assert property (
      (dpValid_ff && dpWrite_ff && dpAddr_ff == OFF_RESULT && pushIf.ready) |-> HREADYOUT)
      else $error("data write stalled with room in buffer");

   chk_write_nostore: assert property (
      (resultWr && !busyAny && !restart) |=> (result_ff == $past(result_ff)))
      else $error("data write stored into result directly");

   chk_high_masked: assert property (
      (dpDone && !dpWrite_ff && dpAddr_ff == OFF_RESULT && size_ff == SZ16 && !revOut_ff)
      |-> (HRDATA[31:16] == 16'h0000))
      else $error("high result bits visible for 16-bit size");

   cov_word32: cover property (popFire && size_ff == SZ32 && revIn_ff == REV_WORD);
   cov_fifo_full: cover property (pushIf.valid && !pushIf.ready);
   cov_restart_busy: cover property (restart && engState_ff == ENG_RUN);
   cov_err_resp: cover property (HRESP && HREADYOUT);

endmodule

`default_nettype wire

// ===== bench/crcu_ahb_mst.sv
// crcu_ahb_mst: behavioural bus master that stands in for the cpu or dma.
// assumes one slave on the bus, so the bus-wide ready is the slave's own.
`timescale 1ns/1ps
`default_nettype none

module crcu_ahb_mst
   import crcu_pkg::*;
(
   input  wire logic              core_clk,   // bus clock
   output var  logic              HSEL,       // slave select
   output var  logic [ADDR_W-1:0] HADDR,      // byte address
   output var  logic [1:0]        HTRANS,     // transfer type
   output var  logic              HWRITE,     // write when high
   output var  logic [2:0]        HSIZE,      // transfer size
   output var  logic [31:0]       HWDATA,     // write data
   output logic                   HREADY,     // bus ready
   input  wire logic [31:0]       HRDATA,     // read data
   input  wire logic              HREADYOUT,  // slave ready
   input  wire logic              HRESP       // error response
);
   assign HREADY = HREADYOUT;

   initial begin
      HSEL   = 1'b0;
      HADDR  = '0;
      HTRANS = 2'h0;
      HWRITE = 1'b0;
      HSIZE  = HSIZE_WORD;
      HWDATA = '0;
   end

   // caller enters just after an edge; returns just after the closing edge
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                       input logic [2:0] sz, output logic [31:0] rd, output logic err,
                       output int waits);
      waits  = 0;
      HSEL   = 1'b1;
      HADDR  = a;
      HTRANS = 2'h2;
      HWRITE = wr;
      HSIZE  = sz;
      @(posedge core_clk);
      #1;
      HSEL   = 1'b0;
      HTRANS = 2'h0;
      HADDR  = ~a;
      HWDATA = wd;
      do begin
         @(posedge core_clk);
         waits++;
      end while (HREADYOUT !== 1'b1 && waits < 64);
      waits--;
      rd  = HRDATA;
      err = HRESP;
      #1;
      // released data bus must not keep showing the old word
      HWDATA = ~wd;
   endtask
endmodule

`default_nettype wire

// ===== bench/tb.sv
// tb: self-checking bench for crcu_top, register calls against a reference model.
// assumes crcu_pkg and the behavioural bus master are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb;
   import crcu_pkg::*;
   logic              core_clk, nrst, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, err, ro;
   logic [ADDR_W-1:0] HADDR;
   logic [1:0]        HTRANS, sz, ri;
   logic [2:0]        HSIZE;
   logic [31:0]       HWDATA, HRDATA, rdVal, expCrc, gen, initV;
   logic [31:0]       gens [4] = '{32'h04C11DB7, 32'h00001021, 32'h00000007, 32'h00000009};
   logic [31:0]       cycs [4] = '{32'h4, 32'h2, 32'h1, 32'h1};
   int                miscompares, checks, waits, total;

   crcu_top i_dut (.core_clk(core_clk), .nrst(nrst), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP));
   crcu_ahb_mst i_mst (.core_clk(core_clk), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP));

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %08h expected %08h", $time, seen, exp);
      end
   endtask

   // the master gives up after 64 edges; a hung data phase counts as a mismatch
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      i_mst.xfer(1'b1, a, d, HSIZE_WORD, rdVal, err, waits);
      if (waits >= 63) miscompares++;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a);
      i_mst.xfer(1'b0, a, 32'h0, HSIZE_WORD, rdVal, err, waits);
      if (waits >= 63) miscompares++;
   endtask

   task automatic ctl(input logic restart);
      wr(OFF_CONTROL, {24'h0, ro, ri, sz, 2'b00, restart});
      if (restart) expCrc = initV;
   endtask

   function automatic logic [31:0] rev(input logic [31:0] x, input int n);
      logic [31:0] y;
      for (int i = 0; i < 32; i++) y[i] = x[(i / n) * n + n - 1 - i % n];
      return y;
   endfunction

   function automatic int wid(input logic [1:0] s);
      return (s == SZ32) ? 32 : (s == SZ16) ? 16 : (s == SZ8) ? 8 : 7;
   endfunction

   function automatic logic [31:0] msk(input logic [1:0] s);
      return (s == SZ32) ? 32'hFFFFFFFF : (32'h1 << wid(s)) - 32'h1;
   endfunction

   // msb first, non-reflected; short sizes use only the low bytes
   task automatic fold(input logic [31:0] d);
      logic [31:0] x;
      logic        fb;
      int          w;
      w = wid(sz);
      x = (ri == REV_NONE) ? d : rev(d, 4 << ri);
      for (int b = (w == 32) ? 31 : (w == 16) ? 15 : 7; b >= 0; b--) begin
         fb = expCrc[w - 1] ^ x[b];
         expCrc = (expCrc << 1) & msk(sz);
         if (fb) expCrc = expCrc ^ (gen & msk(sz));
      end
   endtask

   function automatic logic [31:0] view();
      logic [31:0] r;
      r = expCrc & msk(sz);
      return ro ? rev(r, 32) : r;
   endfunction

   task automatic end_of_test();
      $display("Checks %0d, miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      repeat (4000) @(posedge core_clk);
      miscompares++;
      end_of_test();
   end

   initial begin
      miscompares = 0;
      checks = 0;
      nrst = 1'b0;
      expCrc = 32'hFFFFFFFF;
      initV = 32'hFFFFFFFF;
      gen = 32'h04C11DB7;
      {sz, ri, ro} = '0;
      repeat (10) @(posedge core_clk);
      #1 nrst = 1'b1;
      rd(OFF_RESULT);  chk(rdVal, 32'hFFFFFFFF);
      rd(OFF_SCRATCH); chk(rdVal, 32'h0);
      rd(OFF_CONTROL); chk(rdVal, 32'h0);
      rd(OFF_INITVAL); chk(rdVal, 32'hFFFFFFFF);
      rd(OFF_GENVAL);  chk(rdVal, 32'h04C11DB7);
      rd(5'h0C);       chk({31'h0, err}, 32'h1);
      $display("Test reset_values done");

      // second word lands while the first is still being folded
      wr(OFF_RESULT, 32'h3456CDEF); fold(32'h3456CDEF);
      wr(OFF_RESULT, 32'h0BADF00D); fold(32'h0BADF00D);
      chk(32'(waits), 32'h0);
      rd(OFF_RESULT); chk(rdVal, view());
      $display("Test chained_words done");

      wr(OFF_SCRATCH, 32'hFFFFFFA5);
      rd(OFF_SCRATCH); chk(rdVal, 32'hA5);
      i_mst.xfer(1'b1, OFF_SCRATCH, 32'h5A, 3'h0, rdVal, err, waits);
      rd(OFF_SCRATCH); chk(rdVal, 32'hA5);
      wr(OFF_INITVAL, 32'h12345678); initV = 32'h12345678; expCrc = initV;
      rd(OFF_RESULT); chk(rdVal, 32'h12345678);
      wr(OFF_RESULT, 32'hDEADBEEF); fold(32'hDEADBEEF);
      // result read stalls until the word is folded, so the restart finds the engine idle
      rd(OFF_RESULT);  chk(rdVal, view());
      ctl(1'b1);
      rd(OFF_CONTROL); chk(rdVal, 32'h0);
      rd(OFF_RESULT);  chk(rdVal, 32'h12345678);
      rd(OFF_SCRATCH); chk(rdVal, 32'hA5);
      $display("Test scratch_restart done");

      for (int i = 0; i < 4; i++) begin
         sz = 2'(i);
         ri = 2'(i);
         ro = i[1];
         gen = gens[i];
         wr(OFF_GENVAL, gen);
         ctl(1'b1);
         rd(OFF_CONTROL); chk(rdVal, {24'h0, ro, ri, sz, 3'b000});
         wr(OFF_RESULT, 32'hC3A51E96 ^ 32'(i)); fold(32'hC3A51E96 ^ 32'(i));
         rd(OFF_RESULT);
         chk(32'(waits), cycs[i]);
         chk(rdVal, view());
      end
      $display("Test size_and_reverse done");

      {sz, ri, ro} = '0;
      gen = gens[0];
      wr(OFF_GENVAL, gen);
      ctl(1'b1);
      total = 0;
      // outruns the engine so the queue fills and must hold the bus
      for (int k = 0; k < 16; k++) begin
         wr(OFF_RESULT, 32'h10000000 + 32'(k));
         fold(32'h10000000 + 32'(k));
         total += waits;
      end
      chk(32'(total > 0), 32'h1);
      rd(OFF_RESULT); chk(rdVal, view());
      $display("Test queue_fill done");
      end_of_test();
   end
endmodule

`default_nettype wire
